// ---- rtl/pmp_ctrl.sv ----
// Purpose: pump turn-on control, bottom contact flag and modem command split
// Assumes: reset is asserted at every power-up; modem bytes arrive on clk
// Notes: registers on APB, always ready, one wait-free access phase
`timescale 1ns/1ps
`include "pmp_params.svh"
module pmp_ctrl #(
   parameter logic [35:0] DELAY_CYCLES = `PMP_DELAY_CYCLES,
   parameter logic [31:0] GATE_CYCLES = `PMP_GATE_CYCLES,
   parameter logic [31:0] THRESH_COUNT = `PMP_MIN_FREQ_HZ
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input pmp_pkg::pmp_apb_req_s apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sensor pins
   input wire logic primary_cond_freq,
   input wire logic aux_contact_in,
   // modem channel in, sampler traffic out
   input wire logic mdm_valid,
   input wire logic [7:0] mdm_byte,
   output logic smp_valid,
   output logic [7:0] smp_byte,
   // pump, scan flags, interrupt
   output logic pump_on,
   output pmp_pkg::pmp_scan_flags_s scan_flags,
   output logic irq
);
   import pmp_pkg::*;

   localparam logic [2:0] SEL_CTRL = 3'h0;
   localparam logic [2:0] SEL_STATUS = 3'h1;
   localparam logic [2:0] SEL_FREQ = 3'h2;
   localparam logic [2:0] SEL_ISTAT = 3'h3;
   localparam logic [2:0] SEL_ICLR = 3'h4;
   localparam logic [2:0] SEL_IEN = 3'h5;
   localparam logic [2:0] SEL_NONE = 3'h7;

   // address decode shared by the setup-phase read and the access-phase write
   function automatic logic [2:0] reg_sel(input logic [11:0] addr);
      case (addr)
         `PMP_OFF_CTRL: reg_sel = SEL_CTRL;
         `PMP_OFF_STATUS: reg_sel = SEL_STATUS;
         `PMP_OFF_FREQ: reg_sel = SEL_FREQ;
         `PMP_OFF_IRQ_STAT: reg_sel = SEL_ISTAT;
         `PMP_OFF_IRQ_CLR: reg_sel = SEL_ICLR;
         `PMP_OFF_IRQ_EN: reg_sel = SEL_IEN;
         default: reg_sel = SEL_NONE;
      endcase
   endfunction : reg_sel

   logic cond_s, aux_s;
   logic [31:0] freq_w;
   logic freq_valid_w;

   pmp_sync u_sync_cond (
      .clk(clk),
      .reset(reset),
      .pin(primary_cond_freq),
      .level(cond_s)
   );

   pmp_sync u_sync_aux (
      .clk(clk),
      .reset(reset),
      .pin(aux_contact_in),
      .level(aux_s)
   );

   // only the primary channel is measured; no secondary input exists
   pmp_freq_meter #(
      .GATE_CYCLES(GATE_CYCLES)
   ) u_meter (
      .clk(clk),
      .reset(reset),
      .sig(cond_s), // [RQ1]
      .freq(freq_w),
      .valid(freq_valid_w)
   );

   pmp_opt_e opt_q;
   pmp_state_e state_q, state_d;
   logic [35:0] dly_q, dly_d;
   logic pump_q;
   logic restart;
   logic cond_met, wet, cmd_on, cmd_off, cmd_hit;
   logic bottom;
   logic [2:0] wsel, rsel;
   logic acc, wr;
   logic [31:0] prdata_q;
   logic [`PMP_IRQ_W-1:0] ist_q, ien_q, ev, iclr;
   logic bottom_prev_q;
   pmp_scan_flags_s flags_q;
   logic smp_valid_q;
   logic [7:0] smp_byte_q;

   assign acc = apb_req.psel & apb_req.penable;
   assign wr = acc & apb_req.pwrite;
   assign wsel = reg_sel(apb_req.paddr);
   assign rsel = wsel;
   assign pready = 1'b1;
   assign pslverr = acc & (wsel == SEL_NONE);

   // threshold is a constant, not software-writable, so drift in air cannot be tuned in
   assign cond_met = (opt_q == OPT_STD) & freq_valid_w & (freq_w > THRESH_COUNT); // [RQ2] [RQ3]
   assign wet = (opt_q == OPT_WATER) & aux_s; // [RQ12]
   assign cmd_hit = mdm_valid & (opt_q == OPT_MANUAL) &
                    ((mdm_byte == `PMP_CMD_ON) | (mdm_byte == `PMP_CMD_OFF));
   assign cmd_on = cmd_hit & (mdm_byte == `PMP_CMD_ON); // [RQ7]
   assign cmd_off = cmd_hit & (mdm_byte == `PMP_CMD_OFF); // [RQ7]

   // a change of option restarts the sequence like a power cycle would
   assign restart = wr & (wsel == SEL_CTRL) & (apb_req.pwdata[1:0] != 2'h3) &
                    (apb_req.pwdata[1:0] != opt_q);

   always_ff @(posedge clk) begin
      if (reset) begin
         opt_q <= pmp_opt_e'(`PMP_RST_OPT);
      end else if (restart) begin
         opt_q <= pmp_opt_e'(apb_req.pwdata[1:0]);
      end
   end

   always_comb begin
      state_d = state_q;
      dly_d = dly_q;
      case (state_q)
         ST_IDLE: begin
            dly_d = 36'h0; // [RQ17]
            if (cond_met | wet) begin
               state_d = ST_DELAY; // [RQ4] [RQ10]
            end else if (cmd_on) begin
               state_d = ST_ON; // [RQ8]
            end
         end
         ST_DELAY: begin
            dly_d = dly_q + 36'h1;
            if ((opt_q == OPT_WATER) & ~wet) begin
               state_d = ST_IDLE; // [RQ11]
            end else if (dly_q == DELAY_CYCLES - 36'h1) begin
               state_d = ST_ON; // [RQ4] [RQ10]
            end
         end
         ST_ON: begin
            if ((opt_q == OPT_WATER) & ~wet) begin
               state_d = ST_IDLE; // [RQ11]
            end else if (cmd_off) begin
               state_d = ST_IDLE; // [RQ7]
            end
            // standard option has no exit from here short of reset or a change of option
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      if (restart) begin
         state_d = ST_IDLE;
         dly_d = 36'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= ST_IDLE; // [RQ6] [RQ17]
         dly_q <= 36'h0;
      end else begin
         state_q <= state_d; // [RQ18]
         dly_q <= dly_d;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pump_q <= 1'b0; // [RQ6] [RQ17]
      end else begin
         pump_q <= (state_d == ST_ON);
      end
   end

   // aux connector carries the immersion pin in water-contact mode
   assign bottom = (opt_q != OPT_WATER) & aux_s; // [RQ13] [RQ14]

   always_ff @(posedge clk) begin
      if (reset) begin
         flags_q <= '0;
         bottom_prev_q <= 1'b0;
      end else begin
         flags_q.bottom_contact <= bottom; // [RQ15]
         flags_q.pump_on <= pump_q;
         bottom_prev_q <= bottom;
      end
   end

   // pump bytes are consumed only in manual mode; all else passes in order
   always_ff @(posedge clk) begin
      if (reset) begin
         smp_valid_q <= 1'b0;
         smp_byte_q <= 8'h0;
      end else begin
         smp_valid_q <= mdm_valid & ~cmd_hit; // [RQ9]
         if (mdm_valid) begin
            smp_byte_q <= mdm_byte; // [RQ9]
         end
      end
   end

   always_comb begin
      ev = '0;
      ev[`PMP_IRQ_COND] = (state_q == ST_IDLE) & (state_d == ST_DELAY);
      ev[`PMP_IRQ_START] = ~pump_q & (state_d == ST_ON);
      ev[`PMP_IRQ_STOP] = pump_q & (state_d != ST_ON);
      ev[`PMP_IRQ_BOTTOM] = bottom & ~bottom_prev_q;
   end

   assign iclr = (wr & (wsel == SEL_ICLR)) ? apb_req.pwdata[`PMP_IRQ_W-1:0] : '0;

   // set beats clear so an event in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (reset) begin
         ist_q <= '0;
      end else begin
         ist_q <= (ist_q & ~iclr) | ev;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ien_q <= '0;
      end else if (wr & (wsel == SEL_IEN)) begin
         ien_q <= apb_req.pwdata[`PMP_IRQ_W-1:0];
      end
   end

   // read data is captured in the setup cycle so pready can stay high
   always_ff @(posedge clk) begin
      if (reset) begin
         prdata_q <= 32'h0;
      end else if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
         case (rsel)
            SEL_CTRL: prdata_q <= {30'h0, opt_q};
            SEL_STATUS: prdata_q <= {27'h0, bottom, aux_s, (state_q == ST_DELAY),
                                     cond_met, pump_q};
            SEL_FREQ: prdata_q <= freq_w;
            SEL_ISTAT: prdata_q <= {{(32-`PMP_IRQ_W){1'b0}}, ist_q};
            SEL_IEN: prdata_q <= {{(32-`PMP_IRQ_W){1'b0}}, ien_q};
            default: prdata_q <= 32'h0;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pump_on = pump_q;
   assign scan_flags = flags_q;
   assign smp_valid = smp_valid_q;
   assign smp_byte = smp_byte_q;
   assign irq = |(ist_q & ien_q);
endmodule : pmp_ctrl

// ---- rtl/pmp_params.svh ----
// Purpose: constants of the pump turn-on control block
// Assumes: 250 MHz clock, power-on equals synchronous reset
// Notes: rules carried by this block follow
// Function
// (RQ1) standard start uses only the primary conductivity frequency input
// (RQ2) conductivity condition met only when measured frequency exceeds fixed threshold
// (RQ3) threshold fixed far above zero-conductivity frequency so drift in air fails
// (RQ4) pump energised only after 60 s delay following conductivity detection
// (RQ5) operator waits at least one minute submerged before descending
// (RQ6) power cycling (reset) restarts the turn-on sequence from the start
// (RQ7) manual option: pump switches only on relayed modem on/off commands
// (RQ8) manual option never starts the pump automatically
// (RQ9) pump command handling leaves sampler traffic on the modem channel intact
// (RQ10) water-contact option starts pump 60 s after pin indicates immersion
// (RQ11) water-contact option stops pump as soon as pin leaves water
// (RQ12) water-contact switching ignores conductivity frequency entirely
// (RQ13) water-contact option on aux connector disables the bottom contact indication
// (RQ14) open bottom switch means no bottom contact, flag clear
// (RQ15) closed bottom switch sets flag in every scan while closed
// (RQ16) surface unit raises alarm whenever the flag is received set
// (RQ17) after power-up pump off, timer clear until start condition newly met
// (RQ18) standard option keeps pump on until power is removed
`ifndef PMP_PARAMS_SVH
`define PMP_PARAMS_SVH
`define PMP_CLK_HZ 250000000
`define PMP_DELAY_S 60
`define PMP_DELAY_CYCLES (36'(64'(`PMP_DELAY_S) * 64'(`PMP_CLK_HZ)))
`define PMP_GATE_S 1
`define PMP_GATE_CYCLES (32'(`PMP_GATE_S * `PMP_CLK_HZ))
`define PMP_MIN_FREQ_HZ 32'hdac
`define PMP_CMD_ON 8'hf1
`define PMP_CMD_OFF 8'hf0
`define PMP_OFF_CTRL 12'h000
`define PMP_OFF_STATUS 12'h004
`define PMP_OFF_FREQ 12'h008
`define PMP_OFF_IRQ_STAT 12'h00c
`define PMP_OFF_IRQ_CLR 12'h010
`define PMP_OFF_IRQ_EN 12'h014
`define PMP_RST_OPT 2'h0
`define PMP_IRQ_W 4
`define PMP_IRQ_COND 0
`define PMP_IRQ_START 1
`define PMP_IRQ_STOP 2
`define PMP_IRQ_BOTTOM 3
`endif

// ---- rtl/pmp_pkg.sv ----
// Purpose: types of the pump turn-on control block
// Assumes: pmp_params.svh holds the numbers
// Notes: option codes follow declaration order
package pmp_pkg;
   typedef enum logic [1:0] {OPT_STD, OPT_MANUAL, OPT_WATER} pmp_opt_e;
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_ON} pmp_state_e;
   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } pmp_apb_req_s;
   typedef struct packed {
      logic bottom_contact;
      logic pump_on;
   } pmp_scan_flags_s;
endpackage : pmp_pkg

// ---- rtl/pmp_sync.sv ----
// Purpose: three-stage synchroniser with agreement filter for a pin
// Assumes: pin is asynchronous to clk
// Notes: level moves only when stages two and three agree
`timescale 1ns/1ps
module pmp_sync (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // pin and filtered level
   input wire logic pin,
   output logic level
);
   logic s1_q, s2_q, s3_q, lvl_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         lvl_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         lvl_q <= s3_q;
      end
   end
   assign level = lvl_q;
endmodule : pmp_sync

// ---- rtl/pmp_freq_meter.sv ----
// Purpose: gated edge counter giving raw frequency per gate period
// Assumes: sig is already synchronised
// Notes: result is edges per gate, i.e. Hz with a one second gate
`timescale 1ns/1ps
`include "pmp_params.svh"
module pmp_freq_meter #(
   parameter logic [31:0] GATE_CYCLES = `PMP_GATE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // measured signal and result
   input wire logic sig,
   output logic [31:0] freq,
   output logic valid
);
   logic prev_q, valid_q;
   logic [31:0] gate_q, cnt_q, freq_q;
   logic edge_s;
   assign edge_s = sig & ~prev_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= sig;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         gate_q <= 32'h0;
         cnt_q <= 32'h0;
         freq_q <= 32'h0;
         valid_q <= 1'b0;
      end else if (gate_q == GATE_CYCLES - 32'h1) begin
         gate_q <= 32'h0;
         cnt_q <= 32'h0;
         freq_q <= cnt_q + {31'h0, edge_s};
         valid_q <= 1'b1;
      end else begin
         gate_q <= gate_q + 32'h1;
         cnt_q <= cnt_q + {31'h0, edge_s};
      end
   end
   assign freq = freq_q;
   assign valid = valid_q;
endmodule : pmp_freq_meter

// ---- tb/pmp_ctrl_asserts.sv ----
// Purpose: concurrent checks on the pump control ports
// Assumes: option tracked from apb writes to the control word
// Notes: bound into pmp_ctrl below
`timescale 1ns/1ps
`include "pmp_params.svh"
module pmp_ctrl_asserts #(
   parameter logic [35:0] DELAY_CYCLES = `PMP_DELAY_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // observed ports
   input pmp_pkg::pmp_apb_req_s apb_req,
   input wire logic aux_contact_in,
   input wire logic mdm_valid,
   input wire logic [7:0] mdm_byte,
   input wire logic smp_valid,
   input wire logic [7:0] smp_byte,
   input wire logic pump_on,
   input pmp_pkg::pmp_scan_flags_s scan_flags
);
   import pmp_pkg::*;
   logic wr_ctrl;
   logic [1:0] opt_q;
   logic [35:0] since_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   assign wr_ctrl = apb_req.psel && apb_req.penable && apb_req.pwrite
      && apb_req.paddr == `PMP_OFF_CTRL;
   always_ff @(posedge clk) begin
      if (reset) opt_q <= 2'h0;
      else if (wr_ctrl && apb_req.pwdata[1:0] != 2'h3) opt_q <= apb_req.pwdata[1:0];
   end
   // any option change restarts the wait, so count from it
   always_ff @(posedge clk) begin
      if (reset || (wr_ctrl && apb_req.pwdata[1:0] != 2'h3 && apb_req.pwdata[1:0] != opt_q))
         since_q <= '0;
      else since_q <= since_q + 36'h1;
   end
   a_pump_late: assert property (
      $rose(pump_on) && opt_q != 2'h1 |-> since_q >= DELAY_CYCLES) else $error("pump early");
   a_std_stays_on: assert property (
      opt_q == 2'h0 && pump_on && !wr_ctrl |=> pump_on) else $error("pump dropped");
   a_manual_on: assert property (
      opt_q == 2'h1 && mdm_valid && mdm_byte == `PMP_CMD_ON && !wr_ctrl |=> pump_on)
      else $error("on command lost");
   a_manual_off: assert property (
      opt_q == 2'h1 && mdm_valid && mdm_byte == `PMP_CMD_OFF |=> !pump_on)
      else $error("off command lost");
   a_manual_no_auto: assert property (
      opt_q == 2'h1 && !mdm_valid && !wr_ctrl |=> pump_on == $past(pump_on))
      else $error("manual pump moved alone");
   a_sampler_pass: assert property (
      mdm_valid && !(opt_q == 2'h1 && mdm_byte inside {`PMP_CMD_ON, `PMP_CMD_OFF})
      |=> smp_valid && smp_byte == $past(mdm_byte)) else $error("sampler byte lost");
   a_water_off: assert property (
      $fell(aux_contact_in) && opt_q == 2'h2 |-> ##[1:8] !pump_on) else $error("pump not off");
   a_water_no_flag: assert property (
      opt_q == 2'h2 && $past(opt_q) == 2'h2 |-> !scan_flags.bottom_contact)
      else $error("flag in water mode");
   a_flag_closed: assert property (
      (aux_contact_in && opt_q != 2'h2) [*7] |-> scan_flags.bottom_contact)
      else $error("flag missing");
   a_flag_open: assert property (
      !aux_contact_in [*7] |-> !scan_flags.bottom_contact) else $error("flag while open");
endmodule : pmp_ctrl_asserts

bind pmp_ctrl pmp_ctrl_asserts #(.DELAY_CYCLES(DELAY_CYCLES)) i_asserts (.clk(clk),
   .reset(reset), .apb_req(apb_req), .aux_contact_in(aux_contact_in),
   .mdm_valid(mdm_valid), .mdm_byte(mdm_byte), .smp_valid(smp_valid), .smp_byte(smp_byte),
   .pump_on(pump_on), .scan_flags(scan_flags));

// ---- tb/pmp_deck.sv ----
// Purpose: surface deck unit model: alarm, power and modem relay
// Assumes: shares the instrument clock
// Notes: released byte lines show the inverse of the last byte
`timescale 1ns/1ps
module pmp_deck (
   // clock and scan stream in
   input wire logic clk,
   input pmp_pkg::pmp_scan_flags_s scan_flags,
   // alarm, power and modem out
   output logic alarm,
   output logic power_reset,
   output logic mdm_valid,
   output logic [7:0] mdm_byte
);
   import pmp_pkg::*;
   initial begin
      power_reset = 1'b1;
      mdm_valid = 1'b0;
      mdm_byte = 8'h00;
   end
   always_ff @(posedge clk) alarm <= scan_flags.bottom_contact;
   task automatic relay(input logic [7:0] b);
      @(posedge clk);
      mdm_valid <= 1'b1;
      mdm_byte <= b;
      @(posedge clk);
      mdm_valid <= 1'b0;
      mdm_byte <= ~b;
   endtask : relay
   task automatic power_cycle();
      @(posedge clk);
      power_reset <= 1'b1;
      repeat (10) @(posedge clk);
      power_reset <= 1'b0;
   endtask : power_cycle
endmodule : pmp_deck

// ---- tb/pmp_ctrl_tb_top.sv ----
// Purpose: self-checking bench of the pump control block
// Assumes: shortened delay 200, gate 100, threshold 10
// Notes: frequency pin toggles every hp cycles
`timescale 1ns/1ps
`include "pmp_params.svh"
module pmp_ctrl_tb_top;
   import pmp_pkg::*;
   logic clk = 1'b0;
   logic reset;
   pmp_apb_req_s req = '0;
   logic [31:0] prdata;
   logic [31:0] r;
   logic pready;
   logic pslverr;
   logic err;
   logic freq = 1'b0;
   logic aux = 1'b0;
   logic mdm_valid;
   logic [7:0] mdm_byte;
   logic smp_valid;
   logic [7:0] smp_byte;
   logic [7:0] last_smp = 8'h00;
   logic pump_on;
   pmp_scan_flags_s scan_flags;
   logic irq;
   logic alarm;
   int hp = 20;
   int n;
   int fails = 0;
   int checked = 0;
   pmp_ctrl #(.DELAY_CYCLES(36'd200), .GATE_CYCLES(32'd100), .THRESH_COUNT(32'd10)) i_dut (
      .clk(clk), .reset(reset), .apb_req(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .primary_cond_freq(freq), .aux_contact_in(aux),
      .mdm_valid(mdm_valid), .mdm_byte(mdm_byte), .smp_valid(smp_valid),
      .smp_byte(smp_byte), .pump_on(pump_on), .scan_flags(scan_flags), .irq(irq));
   pmp_deck i_deck (.clk(clk), .scan_flags(scan_flags), .alarm(alarm),
      .power_reset(reset), .mdm_valid(mdm_valid), .mdm_byte(mdm_byte));
   initial forever #2 clk = ~clk;
   initial forever begin
      repeat (hp) @(posedge clk);
      freq <= ~freq;
   end
   always @(posedge clk) if (smp_valid === 1'b1) last_smp <= smp_byte;
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{a, 1'b1, 1'b0, w, d};
      @(posedge clk);
      req.penable <= 1'b1;
      // no fixed wait count: only the watchdog ends a hung access
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   task automatic wait_pump(input logic lvl, input int lim);
      n = 0;
      while (pump_on !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_pump
   task automatic close_out();
      if (fails == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      close_out();
   end
   initial begin
      i_deck.power_cycle();
      @(negedge clk);
      chk(pump_on, 1'h0);
      apb(1'b0, `PMP_OFF_CTRL, 32'h0);
      chk(r, `PMP_RST_OPT);
      apb(1'b1, `PMP_OFF_CTRL, 32'h3);
      apb(1'b0, `PMP_OFF_CTRL, 32'h0);
      chk(r, 32'h0);
      apb(1'b1, `PMP_OFF_IRQ_EN, 32'hf);
      repeat (600) @(posedge clk);
      chk(pump_on, 1'h0);
      hp = 3;
      wait_pump(1'b1, 600);
      chk(n > 200 && n < 500, 1'h1);
      chk(irq, 1'h1);
      apb(1'b0, `PMP_OFF_IRQ_STAT, 32'h0);
      chk(r, 32'h3);
      hp = 20;
      repeat (500) @(posedge clk);
      chk({pump_on, scan_flags.pump_on}, 2'h3);
      apb(1'b1, `PMP_OFF_IRQ_CLR, 32'hf);
      apb(1'b0, `PMP_OFF_IRQ_STAT, 32'h0);
      chk({irq, r}, 33'h0);
      apb(1'b0, 12'h100, 32'h0);
      chk({err, r}, {1'b1, 32'h0});
      hp = 3;
      i_deck.power_cycle();
      @(negedge clk);
      chk(pump_on, 1'h0);
      wait_pump(1'b1, 600);
      chk(n > 200, 1'h1);
      apb(1'b1, `PMP_OFF_CTRL, 32'h1);
      repeat (600) @(posedge clk);
      chk(pump_on, 1'h0);
      i_deck.relay(8'h55);
      i_deck.relay(`PMP_CMD_ON);
      @(negedge clk);
      chk(pump_on, 1'h1);
      i_deck.relay(`PMP_CMD_OFF);
      @(negedge clk);
      chk(pump_on, 1'h0);
      // one more cycle so a wrongly forwarded command byte would have landed
      @(negedge clk);
      chk(last_smp, 8'h55);
      hp = 20;
      apb(1'b1, `PMP_OFF_CTRL, 32'h2);
      aux <= 1'b1;
      wait_pump(1'b1, 400);
      chk(n >= 200 && n < 215, 1'h1);
      chk(scan_flags.bottom_contact, 1'h0);
      apb(1'b0, `PMP_OFF_STATUS, 32'h0);
      chk(r, 32'h9);
      @(posedge clk);
      aux <= 1'b0;
      wait_pump(1'b0, 20);
      chk(n < 8, 1'h1);
      apb(1'b1, `PMP_OFF_CTRL, 32'h0);
      aux <= 1'b1;
      repeat (8) @(negedge clk);
      chk({scan_flags.bottom_contact, alarm}, 2'h3);
      // the power cycle cleared the enables, so arm the bottom event again
      apb(1'b1, `PMP_OFF_IRQ_EN, 32'h8);
      apb(1'b0, `PMP_OFF_IRQ_STAT, 32'h0);
      chk({irq, r[3]}, 2'h3);
      apb(1'b1, `PMP_OFF_IRQ_EN, 32'h0);
      @(negedge clk);
      chk(irq, 1'h0);
      aux <= 1'b0;
      repeat (8) @(negedge clk);
      chk({scan_flags.bottom_contact, alarm}, 2'h0);
      close_out();
   end
endmodule : pmp_ctrl_tb_top
